// ### logic/bwsic_pkg.sv
// Package of the wait-sampling and idle-cycle control block.
// Assumes a single clk_sys domain and a plain register port.
package bwsic_pkg;
    // Register index and layout of the control register
    localparam logic [3:0] BWSIC_CTRL_ADDR = 4'h0;
    localparam int BWSIC_WAIT_SEL_BIT = 15;
    localparam logic [15:0] BWSIC_CTRL_RESET = 16'h3ff3;
    localparam logic [15:0] BWSIC_CTRL_WMASK = 16'hbff3;
    // Idle-count field low bit for each area that has one (area n at 2n)
    localparam int BWSIC_AREA0_POS = 0;
    localparam int BWSIC_AREA2_POS = 4;
    localparam int BWSIC_AREA3_POS = 6;
    localparam int BWSIC_AREA4_POS = 8;
    localparam int BWSIC_AREA5_POS = 10;
    localparam int BWSIC_AREA6_POS = 12;
    // Idle count for areas that have no field of their own
    localparam logic [1:0] BWSIC_IDLE_DEFAULT = 2'h1;

    typedef enum logic [1:0] {
        BWSIC_IDLE = 2'h0,
        BWSIC_ACCESS = 2'h1,
        BWSIC_GAP = 2'h3
    } bwsic_state_t;

    typedef struct packed {
        logic valid;
        logic [2:0] area;
        logic write;
    } bwsic_req_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] rdata;
        logic bus_clk;
        bwsic_state_t state;
        logic [1:0] cnt;
        logic last_valid;
        logic [2:0] last_area;
        logic last_write;
        logic strobe;
        logic wait_hold;
        logic ack;
    } bwsic_regs_t;
endpackage : bwsic_pkg

// ### logic/bwsic_top.sv
// Control register and idle-cycle sequencer of the external bus controller.
// Assumes requests and the wait input are synchronous to clk_sys.
// Functional notes
// R1: With the select bit at 1 the wait input is sampled at the falling edge of the bus clock.
// R2: Software sets the select bit before any device uses wait; the bit resets to 0.
// R3: Devices keep wait deasserted while the select bit is 0.
// R4: Bits 14, 3 and 2 are reserved and always read as 0.
// R5: Software writes 0 to the reserved bits.
// R6: Areas 6 to 2 and 0 each own a two-bit idle field at bits 2n+1 and 2n.
// R7: Field 00 or 01 gives 1 idle cycle, 10 gives 2, 11 gives 3; fields reset to 11.
// R8: Idle cycles go in when consecutive accesses switch to another area.
// R9: Idle cycles go in between a read and a write in the same area.
// R10: No strobe is driven during idle cycles and the next access waits out the full count.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bwsic_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire bwsic_pkg::bwsic_req_t req,
    output logic req_ack,
    input wire logic ext_wait_n,
    output logic bus_clock_output,
    output logic access_strobe,
    output logic access_write,
    output logic [2:0] access_area,
    output logic wait_sample_edge_select
);
    bwsic_pkg::bwsic_regs_t r_reg;
    bwsic_pkg::bwsic_regs_t r_next;
    logic [1:0] fld;
    logic [1:0] idle_n;
    logic need_idle;
    logic tick_rise;
    logic tick_fall;

    // Field of the requested area
    always_comb begin
        unique case (req.area)
            3'h0: fld = r_reg.ctrl[bwsic_pkg::BWSIC_AREA0_POS +: 2]; // [R6]
            3'h2: fld = r_reg.ctrl[bwsic_pkg::BWSIC_AREA2_POS +: 2]; // [R6]
            3'h3: fld = r_reg.ctrl[bwsic_pkg::BWSIC_AREA3_POS +: 2]; // [R6]
            3'h4: fld = r_reg.ctrl[bwsic_pkg::BWSIC_AREA4_POS +: 2]; // [R6]
            3'h5: fld = r_reg.ctrl[bwsic_pkg::BWSIC_AREA5_POS +: 2]; // [R6]
            3'h6: fld = r_reg.ctrl[bwsic_pkg::BWSIC_AREA6_POS +: 2]; // [R6]
            default: fld = bwsic_pkg::BWSIC_IDLE_DEFAULT;
        endcase
        // 00 and 01 both mean one idle cycle
        idle_n = (fld == 2'h0) ? 2'h1 : fld; // [R7]
        need_idle = r_reg.last_valid
            && ((req.area != r_reg.last_area) // [R8]
            || (req.write != r_reg.last_write)); // [R9]
    end

    assign tick_rise = !r_reg.bus_clk;
    assign tick_fall = r_reg.bus_clk;

    // Next state of registers, bus clock and sequencer
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.bus_clk = !r_reg.bus_clk;
        if (reg_wr && reg_addr == bwsic_pkg::BWSIC_CTRL_ADDR) begin
            r_next.ctrl = reg_wdata & bwsic_pkg::BWSIC_CTRL_WMASK; // [R4]
        end
        if (reg_rd) begin
            r_next.rdata = (reg_addr == bwsic_pkg::BWSIC_CTRL_ADDR)
                ? (r_reg.ctrl & bwsic_pkg::BWSIC_CTRL_WMASK) : 16'h0000; // [R4]
        end
        // Wait is looked at only at the bus clock falling edge
        if (tick_fall && r_reg.state == bwsic_pkg::BWSIC_ACCESS) begin
            r_next.wait_hold = r_reg.ctrl[bwsic_pkg::BWSIC_WAIT_SEL_BIT]
                && !ext_wait_n; // [R1]
        end
        if (tick_rise) begin
            unique case (r_reg.state)
                bwsic_pkg::BWSIC_IDLE, bwsic_pkg::BWSIC_ACCESS: begin
                    if (r_reg.state == bwsic_pkg::BWSIC_ACCESS && r_reg.wait_hold) begin
                        r_next.strobe = 1'b1;
                    end else if (req.valid && need_idle) begin
                        // Strobe dropped for the whole gap
                        r_next.strobe = 1'b0; // [R10]
                        r_next.state = bwsic_pkg::BWSIC_GAP;
                        r_next.cnt = idle_n - 2'h1;
                    end else if (req.valid) begin
                        r_next.strobe = 1'b1;
                        r_next.ack = 1'b1;
                        r_next.state = bwsic_pkg::BWSIC_ACCESS;
                        r_next.last_valid = 1'b1;
                        r_next.last_area = req.area;
                        r_next.last_write = req.write;
                        r_next.wait_hold = 1'b0;
                    end else begin
                        r_next.strobe = 1'b0;
                        r_next.state = bwsic_pkg::BWSIC_IDLE;
                    end
                end
                bwsic_pkg::BWSIC_GAP: begin
                    // Access starts only once the count has run out
                    if (r_reg.cnt == 2'h0) begin // [R10]
                        r_next.strobe = 1'b1;
                        r_next.ack = 1'b1;
                        r_next.state = bwsic_pkg::BWSIC_ACCESS;
                        r_next.last_valid = 1'b1;
                        r_next.last_area = req.area;
                        r_next.last_write = req.write;
                        r_next.wait_hold = 1'b0;
                    end else begin
                        r_next.cnt = r_reg.cnt - 2'h1;
                    end
                end
                default: begin
                    r_next.state = bwsic_pkg::BWSIC_IDLE;
                    r_next.strobe = 1'b0;
                end
            endcase
        end
    end

    // State register; clk_en freezes everything
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.ctrl <= bwsic_pkg::BWSIC_CTRL_RESET; // [R2] [R7]
            r_reg.state <= bwsic_pkg::BWSIC_IDLE;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign req_ack = r_reg.ack;
    assign bus_clock_output = r_reg.bus_clk;
    assign access_strobe = r_reg.strobe;
    assign access_write = r_reg.last_write;
    assign access_area = r_reg.last_area;
    assign wait_sample_edge_select = r_reg.ctrl[bwsic_pkg::BWSIC_WAIT_SEL_BIT];
endmodule : bwsic_top
`default_nettype wire

// ### verif/bwsic_dev.sv
// Model of an external device stretching accesses with wait.
// Watches strobe and select of bwsic_top in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module bwsic_dev (
    input wire logic clk_sys,
    input wire logic access_strobe,
    input wire logic wait_sample_edge_select,
    input wire logic [1:0] hold_periods,
    output logic ext_wait_n
);
    logic [2:0] cnt_reg;
    // Reload between accesses; back-to-back ones wait only once
    always_ff @(posedge clk_sys) begin
        if (!access_strobe) cnt_reg <= {hold_periods, 1'b0};
        else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
    end
    // Never wait while sampling is off
    assign ext_wait_n = !(wait_sample_edge_select && access_strobe && cnt_reg != 3'h0);
endmodule : bwsic_dev
`default_nettype wire

// ### verif/bwsic_props.sv
// Port checker of the idle-cycle sequencer.
// Bound to bwsic_top; one clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module bwsic_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic req_ack,
    input wire logic ext_wait_n,
    input wire logic bus_clock_output,
    input wire logic access_strobe,
    input wire logic access_write,
    input wire logic [2:0] access_area,
    input wire logic wait_sample_edge_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Wait seen low at the sampling edge of a bus period
    sequence s_wait_seen;
        wait_sample_edge_select && access_strobe && bus_clock_output && !ext_wait_n;
    endsequence
    a_rsv_zero: assert property (reg_rdata[14] == 1'b0 && reg_rdata[3:2] == 2'h0)
        else $error("reserved bit reads one");
    a_sel_copy: assert property (reg_wr && clk_en && reg_addr == 4'h0 |=>
        wait_sample_edge_select == $past(reg_wdata[15])) else $error("select bit lost");
    a_unmapped_zero: assert property (reg_rd && clk_en && reg_addr != 4'h0 |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_ack_strobe: assert property (req_ack |-> access_strobe)
        else $error("ack without strobe");
    a_strobe_min: assert property ($rose(access_strobe) |=> access_strobe)
        else $error("strobe too short");
    a_switch_gap: assert property (req_ack && (access_area != $past(access_area) ||
        access_write != $past(access_write)) |-> $past(access_strobe, 2) == 1'b0 &&
        $past(access_strobe) == 1'b0) else $error("no idle before switch");
    a_wait_hold: assert property (s_wait_seen |-> ##2 access_strobe)
        else $error("wait not honoured");
    a_bus_clk: assert property (clk_en |=> bus_clock_output != $past(bus_clock_output))
        else $error("bus clock stuck");
endmodule : bwsic_props
bind bwsic_top bwsic_props u_props (.*);
`default_nettype wire

// ### verif/bwsic_top_test.sv
// Self-checking bench of the wait-sampling and idle-cycle control block.
// Drives registers and requests; bwsic_dev answers with wait.
`timescale 1ns/1ps
`default_nettype none
module bwsic_top_test;
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    bwsic_pkg::bwsic_req_t req = '0;
    logic req_ack, ext_wait_n, bus_clock_output, access_strobe, access_write;
    logic wait_sample_edge_select;
    logic [2:0] access_area;
    int n_mismatch = 0, samples_checked = 0, n, low, g;
    always #20 clk_sys = ~clk_sys;
    bwsic_top DUT (.*);
    bwsic_dev u_dev (.*, .hold_periods(2'h1));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    // Register port: one-cycle strobes, a quiet cycle after each
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        chk(reg_rdata, exp, "reg_rdata");
    endtask : rd
    // Request held until ack; counts strobe-low clocks before it
    task automatic acc(input logic [2:0] ar, input logic w, input int exp);
        req <= '{valid: 1'b1, area: ar, write: w};
        low = 0;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_sys);
            if (req_ack === 1'b1) break;
            low += int'(access_strobe === 1'b0);
        end
        if (n == 60) begin
            n_mismatch++;
            test_done();
        end
        if (exp >= 0) chk(16'(low), 16'(exp), "idle clocks");
        // Kind and area of the started access stand from the ack cycle on
        chk({13'h0, access_area}, {13'h0, ar}, "access_area");
        chk({15'h0, access_write}, {15'h0, w}, "access_write");
    endtask : acc
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(4'h0, 16'h3ff3);
        rd(4'h5, 16'h0000);
        $display("test reset done");
        // Enable low must freeze the bus clock
        clk_en <= 1'b0;
        @(posedge clk_sys);
        d = {15'h0, bus_clock_output};
        repeat (3) @(posedge clk_sys);
        chk({15'h0, bus_clock_output}, d, "frozen bus clock");
        clk_en <= 1'b1;
        @(posedge clk_sys);
        $display("test clock enable done");
        // Every idle code, select on for the upper two
        for (int v = 0; v < 4; v++) begin
            d = 16'((v * 16'h5555) & 16'h3ff3) | {v[1], 15'h0};
            g = (v == 3) ? 6 : (v == 2) ? 4 : 2;
            wr(4'h0, d);
            rd(4'h0, d);
            chk({15'h0, wait_sample_edge_select}, {15'h0, d[15]}, "select");
            acc(3'h2, 1'b0, -1);
            acc(3'h2, 1'b0, 0);
            acc(3'h2, 1'b1, g);
            acc(3'h3, 1'b1, g);
            acc(3'h6, 1'b0, g);
            acc(3'h0, 1'b0, g);
            req <= '0;
            @(posedge clk_sys);
            $display("test idle code %0d done", v);
        end
        test_done();
    end
endmodule : bwsic_top_test
`default_nettype wire
